// ---- include/dps_pkg.sv ----
// constants for the disk controller phase sequencer
// assumes one 40 MHz clock and the plain host register port
package dps_pkg;

    // host port select: 0 main status, 1 data
    localparam logic       STATUS_ADDR     = 1'h0;
    localparam logic       DATA_ADDR       = 1'h1;

    // main status bit positions
    localparam int         MSR_SERVICE_BIT = 7;
    localparam int         MSR_DIR_BIT     = 6;
    localparam int         MSR_NONDMA_BIT  = 5;
    localparam int         MSR_BUSY_BIT    = 4;

    // opcode layout
    localparam int         OPC_MT_BIT      = 7;
    localparam int         OPC_DD_BIT      = 6;
    localparam int         OPC_SK_BIT      = 5;
    localparam logic [4:0] OPC_READ        = 5'h06;
    localparam logic [4:0] OPC_READ_DEL    = 5'h0C;
    localparam logic [4:0] OPC_WRITE       = 5'h05;

    // second command byte layout
    localparam int         HEAD_SEL_BIT    = 2;
    localparam logic [7:0] UNIT_BYTE_MASK  = 8'h07;

    // command bytes: opcode, unit, C, H, R, N, final sector, gap, length
    localparam int         CMD_BYTES       = 9;
    localparam logic [3:0] CMD_LAST_IDX    = 4'h8;
    localparam logic [3:0] CYL_IDX         = 4'h2;

    // result lengths and codes
    localparam logic [2:0] RES_LEN_READ    = 3'h7;
    localparam logic [2:0] RES_LEN_INVALID = 3'h1;
    localparam logic [2:0] RES_ID_START    = 3'h3;
    localparam logic [7:0] STAT_INVALID    = 8'h80;
    localparam logic [7:0] BYTE_RESET      = 8'h00;

    // nominal byte spacing in double density
    localparam int         BYTE_PERIOD_NS  = 13000;
    localparam int         CLK_PERIOD_NS   = 25;
    localparam int         BYTE_PERIOD_CYC = BYTE_PERIOD_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_CMD,
        ST_EXEC,
        ST_RESULT
    } dps_phase_t;

endpackage : dps_pkg

// ---- core/dps_byte_store.sv ----
// flip-flop store for the command bytes, one entry per byte
// assumes writes come one at a time from the phase sequencer
`timescale 1ns/10ps
`default_nettype none
module dps_byte_store (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // write side
    input  wire logic       wrEn,
    input  wire logic [3:0] wrIdx,
    input  wire logic [7:0] wrData,
    // read side
    input  wire logic [3:0] rdIdx,
    output logic      [7:0] rdData
);

    logic [7:0] entry_q [dps_pkg::CMD_BYTES];
    logic [7:0] entry_d [dps_pkg::CMD_BYTES];

    genvar i;
    generate
        for (i = 0; i < dps_pkg::CMD_BYTES; i++) begin : g_entry
            always_comb begin
                entry_d[i] = entry_q[i];
                if (wrEn && (wrIdx == 4'(i))) begin
                    entry_d[i] = wrData;
                end
            end

            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    entry_q[i] <= dps_pkg::BYTE_RESET;
                end else begin
                    entry_q[i] <= entry_d[i];
                end
            end
        end
    endgenerate

    always_comb begin
        rdData = dps_pkg::BYTE_RESET;
        if (rdIdx < 4'(dps_pkg::CMD_BYTES)) begin
            rdData = entry_q[rdIdx];
        end
    end

endmodule : dps_byte_store
`default_nettype wire

// ---- core/dps_phase_sequencer.sv ----
// command, execution and result phase sequencer of a disk controller
// assumes host strobes are one-cycle pulses synchronous to ref_clk
//
// How it works
// - non-DMA read raises interrupt per byte
// - data read clears interrupt, returns byte
// - write command: data write clears interrupt
// - non-DMA mode: status bit 7 mirrors per-byte request
// - transfer continues until transfer end input
// - DMA mode: no execution phase interrupts
// - DMA request raised per ready byte
// - acknowledge low drops DMA request
// - transfer end raises result interrupt
// - first result read clears interrupt
// - all result bytes read before new command
// - status bytes only in result phase
// - last command byte starts execution
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module dps_phase_sequencer (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // host register port
    input  wire logic       hostAddr,
    input  wire logic [7:0] hostWrData,
    input  wire logic       hostWr,
    input  wire logic       hostRd,
    output logic      [7:0] hostRdData,
    // interrupt and mode
    input  wire logic       nonDmaMode,
    output logic            intrOut,
    // dma handshake
    output logic            dmaReqOut,
    input  wire logic       dmaAckInN,
    input  wire logic       transferEndInput,
    // media side data
    input  wire logic       diskByteValid,
    input  wire logic [7:0] diskByte,
    input  wire logic       diskByteNeed,
    output logic      [7:0] diskWrByte,
    output logic            diskWrValid,
    // media side status
    input  wire logic [7:0] resultStatusA,
    input  wire logic [7:0] resultStatusB,
    input  wire logic [7:0] resultStatusC,
    output logic            busyOut
);

    dps_pkg::dps_phase_t phase_q, phase_d;
    logic [3:0] cmdIdx_q, cmdIdx_d;
    logic [2:0] resIdx_q, resIdx_d;
    logic [2:0] resLen_q, resLen_d;
    logic       isWrite_q, isWrite_d;
    logic       byteReady_q, byteReady_d;
    logic [7:0] dataHold_q, dataHold_d;
    logic [7:0] statA_q, statA_d;
    logic [7:0] statB_q, statB_d;
    logic [7:0] statC_q, statC_d;
    logic       intr_q, intr_d;
    logic       dmaReq_q, dmaReq_d;
    logic [7:0] rdData_q, rdData_d;
    logic [7:0] wrByte_q, wrByte_d;
    logic       wrValid_q, wrValid_d;
    logic       busy_q, busy_d;

    logic       dataSel;
    logic       dataRd;
    logic       dataWr;
    logic       storeWr;
    logic [3:0] storeRdIdx;
    logic [7:0] storeRdData;
    logic [7:0] statusByte;
    logic [7:0] resultByte;

    dps_byte_store u_store (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wrEn    (storeWr),
        .wrIdx   (cmdIdx_q),
        .wrData  (hostWrData),
        .rdIdx   (storeRdIdx),
        .rdData  (storeRdData)
    );

    // dma acknowledge selects the data register regardless of address
    assign dataSel = (hostAddr == dps_pkg::DATA_ADDR) || !dmaAckInN;
    assign dataRd  = hostRd && dataSel;
    assign dataWr  = hostWr && dataSel;
    assign storeWr = (phase_q == dps_pkg::ST_CMD) && dataWr;

    // result id bytes echo the stored cylinder, head, sector, size
    assign storeRdIdx = dps_pkg::CYL_IDX + {1'b0, resIdx_q - dps_pkg::RES_ID_START};

    always_comb begin
        statusByte = 8'h00;
        case (phase_q)
            dps_pkg::ST_CMD: begin
                statusByte[dps_pkg::MSR_SERVICE_BIT] = 1'b1;
            end
            dps_pkg::ST_EXEC: begin
                statusByte[dps_pkg::MSR_SERVICE_BIT] = nonDmaMode && byteReady_q;
                statusByte[dps_pkg::MSR_DIR_BIT]     = !isWrite_q;
                statusByte[dps_pkg::MSR_NONDMA_BIT]  = nonDmaMode;
                statusByte[dps_pkg::MSR_BUSY_BIT]    = 1'b1;
            end
            dps_pkg::ST_RESULT: begin
                statusByte[dps_pkg::MSR_SERVICE_BIT] = 1'b1;
                statusByte[dps_pkg::MSR_DIR_BIT]     = 1'b1;
                statusByte[dps_pkg::MSR_BUSY_BIT]    = 1'b1;
            end
            default: begin
                statusByte = 8'h00;
            end
        endcase
    end

    always_comb begin
        case (resIdx_q)
            3'h0:    resultByte = statA_q;
            3'h1:    resultByte = statB_q;
            3'h2:    resultByte = statC_q;
            default: resultByte = storeRdData;
        endcase
    end

    always_comb begin
        phase_d     = phase_q;
        cmdIdx_d    = cmdIdx_q;
        resIdx_d    = resIdx_q;
        resLen_d    = resLen_q;
        isWrite_d   = isWrite_q;
        byteReady_d = byteReady_q;
        dataHold_d  = dataHold_q;
        statA_d     = statA_q;
        statB_d     = statB_q;
        statC_d     = statC_q;
        intr_d      = intr_q;
        dmaReq_d    = dmaReq_q;
        rdData_d    = dps_pkg::BYTE_RESET;
        wrByte_d    = wrByte_q;
        wrValid_d   = 1'b0;
        busy_d      = busy_q;

        // main status is readable in every phase
        if (hostRd && !dataSel) begin
            rdData_d = statusByte;
        end

        case (phase_q)
            dps_pkg::ST_CMD: begin
                // busy from the opcode byte until the last result byte
                busy_d = (cmdIdx_q != 4'h0);
                if (dataWr) begin
                    cmdIdx_d = cmdIdx_q + 4'h1;
                    if (cmdIdx_q == 4'h0) begin
                        busy_d = 1'b1;
                        case (hostWrData[4:0])
                            dps_pkg::OPC_READ,
                            dps_pkg::OPC_READ_DEL: begin
                                isWrite_d = 1'b0;
                            end
                            dps_pkg::OPC_WRITE: begin
                                isWrite_d = 1'b1;
                            end
                            default: begin
                                // unknown opcode answers one status byte
                                phase_d  = dps_pkg::ST_RESULT;
                                resIdx_d = 3'h0;
                                resLen_d = dps_pkg::RES_LEN_INVALID;
                                statA_d  = dps_pkg::STAT_INVALID;
                                cmdIdx_d = 4'h0;
                            end
                        endcase
                    end else if (cmdIdx_q == dps_pkg::CMD_LAST_IDX) begin
                        phase_d     = dps_pkg::ST_EXEC;
                        byteReady_d = 1'b0;
                        cmdIdx_d    = 4'h0;
                    end
                end
            end

            dps_pkg::ST_EXEC: begin
                busy_d = 1'b1;
                // clears first, so a new byte in the same cycle wins
                if (!dmaAckInN) begin
                    dmaReq_d = 1'b0;
                end
                if (!isWrite_q && dataRd && byteReady_q) begin
                    rdData_d    = dataHold_q;
                    byteReady_d = 1'b0;
                    intr_d      = 1'b0;
                end
                if (isWrite_q && dataWr && byteReady_q) begin
                    wrByte_d    = hostWrData;
                    wrValid_d   = 1'b1;
                    byteReady_d = 1'b0;
                    intr_d      = 1'b0;
                end
                if ((!isWrite_q && diskByteValid) || (isWrite_q && diskByteNeed)) begin
                    if (!isWrite_q) begin
                        dataHold_d = diskByte;
                    end
                    byteReady_d = 1'b1;
                    if (nonDmaMode) begin
                        intr_d = 1'b1;
                    end else begin
                        dmaReq_d = 1'b1;
                    end
                end
                if (!nonDmaMode) begin
                    intr_d = 1'b0;
                end
                // sectors keep flowing until the transfer end input
                if (transferEndInput) begin
                    phase_d     = dps_pkg::ST_RESULT;
                    resIdx_d    = 3'h0;
                    resLen_d    = dps_pkg::RES_LEN_READ;
                    statA_d     = resultStatusA;
                    statB_d     = resultStatusB;
                    statC_d     = resultStatusC;
                    intr_d      = 1'b1;
                    dmaReq_d    = 1'b0;
                    byteReady_d = 1'b0;
                end
            end

            dps_pkg::ST_RESULT: begin
                busy_d   = 1'b1;
                dmaReq_d = 1'b0;
                // writes are ignored until every result byte is read
                if (dataRd) begin
                    rdData_d = resultByte;
                    intr_d   = 1'b0;
                    if (resIdx_q == resLen_q - 3'h1) begin
                        phase_d  = dps_pkg::ST_CMD;
                        resIdx_d = 3'h0;
                        busy_d   = 1'b0;
                    end else begin
                        resIdx_d = resIdx_q + 3'h1;
                    end
                end
            end

            default: begin
                phase_d = dps_pkg::ST_CMD;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            phase_q     <= dps_pkg::ST_CMD;
            cmdIdx_q    <= 4'h0;
            resIdx_q    <= 3'h0;
            resLen_q    <= 3'h0;
            isWrite_q   <= 1'b0;
            byteReady_q <= 1'b0;
            dataHold_q  <= dps_pkg::BYTE_RESET;
            statA_q     <= dps_pkg::BYTE_RESET;
            statB_q     <= dps_pkg::BYTE_RESET;
            statC_q     <= dps_pkg::BYTE_RESET;
            intr_q      <= 1'b0;
            dmaReq_q    <= 1'b0;
            rdData_q    <= dps_pkg::BYTE_RESET;
            wrByte_q    <= dps_pkg::BYTE_RESET;
            wrValid_q   <= 1'b0;
            busy_q      <= 1'b0;
        end else begin
            phase_q     <= phase_d;
            cmdIdx_q    <= cmdIdx_d;
            resIdx_q    <= resIdx_d;
            resLen_q    <= resLen_d;
            isWrite_q   <= isWrite_d;
            byteReady_q <= byteReady_d;
            dataHold_q  <= dataHold_d;
            statA_q     <= statA_d;
            statB_q     <= statB_d;
            statC_q     <= statC_d;
            intr_q      <= intr_d;
            dmaReq_q    <= dmaReq_d;
            rdData_q    <= rdData_d;
            wrByte_q    <= wrByte_d;
            wrValid_q   <= wrValid_d;
            busy_q      <= busy_d;
        end
    end

    assign hostRdData  = rdData_q;
    assign intrOut     = intr_q;
    assign dmaReqOut   = dmaReq_q;
    assign diskWrByte  = wrByte_q;
    assign diskWrValid = wrValid_q;
    assign busyOut     = busy_q;

endmodule : dps_phase_sequencer
`default_nettype wire

// ---- test/dps_dma_model.sv ----
// dma controller model: answers each byte request with ack plus read strobe
// assumes its strobe is or-ed into the host read line by the bench
`timescale 1ns/10ps
`default_nettype none
module dps_dma_model (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // handshake with the sequencer
    input  wire logic       dmaReqOut,
    input  wire logic [7:0] hostRdData,
    input  wire logic [3:0] lag,
    output var  logic       dmaAckInN,
    output var  logic       dmaRd,
    // bytes taken, for the bench
    output var  logic [7:0] gotByte,
    output var  logic       gotValid
);
    logic [1:0] st_q;
    logic [3:0] wait_q;
    always_ff @(posedge ref_clk) begin
        gotValid <= 1'h0;
        if (rst) begin
            {st_q, wait_q, dmaRd, gotByte} <= '0;
            dmaAckInN <= 1'h1;
        end else if (st_q == 2'h0 && dmaReqOut) begin
            wait_q <= wait_q + 4'h1;
            if (wait_q >= lag) begin
                dmaAckInN <= 1'h0;
                dmaRd     <= 1'h1;
                wait_q    <= 4'h0;
                st_q      <= 2'h1;
            end
        end else if (st_q == 2'h1) begin
            dmaAckInN <= 1'h1;
            dmaRd     <= 1'h0;
            st_q      <= 2'h2;
        end else if (st_q == 2'h2) begin
            gotByte  <= hostRdData;
            gotValid <= 1'h1;
            st_q     <= 2'h0;
        end
    end
endmodule : dps_dma_model
`default_nettype wire

// ---- test/dps_phase_sequencer_chk.sv ----
// port assertions for the phase sequencer
// assumes dps_pkg compiled first; bound to every sequencer
`timescale 1ns/10ps
`default_nettype none
module dps_phase_sequencer_chk (
    // clock and reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // host port
    input wire logic       hostAddr,
    input wire logic [7:0] hostWrData,
    input wire logic       hostWr,
    input wire logic       hostRd,
    input wire logic [7:0] hostRdData,
    // mode, interrupt, dma
    input wire logic       nonDmaMode,
    input wire logic       intrOut,
    input wire logic       dmaReqOut,
    input wire logic       dmaAckInN,
    input wire logic       transferEndInput,
    // media side and busy
    input wire logic       diskByteValid,
    input wire logic [7:0] diskByte,
    input wire logic       diskByteNeed,
    input wire logic       busyOut
);
    logic [3:0] cnt_q;
    logic [4:0] op_q;
    logic [7:0] byte_q;
    logic       exec_q, isWr, opOk, dataWr;
    assign dataWr = hostWr && hostAddr;
    assign isWr   = (op_q == dps_pkg::OPC_WRITE);
    assign opOk   = isWr || op_q == dps_pkg::OPC_READ || op_q == dps_pkg::OPC_READ_DEL;
    // shadow of the execution phase, rebuilt from host writes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {cnt_q, exec_q, op_q, byte_q} <= '0;
        end else begin
            if (diskByteValid) byte_q <= diskByte;
            if (!busyOut) cnt_q <= dataWr ? 4'h1 : 4'h0;
            else if (dataWr && cnt_q != 4'h0 && cnt_q < 4'h9) cnt_q <= cnt_q + 4'h1;
            if (!busyOut && dataWr) op_q <= hostWrData[4:0];
            if (busyOut && dataWr && cnt_q == 4'h8) exec_q <= opOk;
            else if (transferEndInput) exec_q <= 1'h0;
        end
    end
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_byte_intr;
        exec_q && nonDmaMode && !isWr && diskByteValid && !transferEndInput |=> intrOut;
    endproperty
    a_byte_intr: assert property (p_byte_intr) else $error("byte gave no interrupt");
    property p_rd_clear;
        exec_q && nonDmaMode && !isWr && hostRd && hostAddr && intrOut && !diskByteValid
            |=> !intrOut && hostRdData == $past(byte_q);
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("data read wrong");
    property p_svc;
        exec_q && nonDmaMode && hostRd && !hostAddr && dmaAckInN
            |=> hostRdData[7] == $past(intrOut);
    endproperty
    a_svc: assert property (p_svc) else $error("service bit differs");
    property p_dma_quiet;
        exec_q && !nonDmaMode && !transferEndInput |=> !intrOut;
    endproperty
    a_dma_quiet: assert property (p_dma_quiet) else $error("interrupt in dma");
    property p_dma_req;
        exec_q && !nonDmaMode && diskByteValid && !transferEndInput |=> dmaReqOut;
    endproperty
    a_dma_req: assert property (p_dma_req) else $error("no dma request");
    property p_ack_drop;
        dmaReqOut && !dmaAckInN && !diskByteValid && !diskByteNeed |=> !dmaReqOut;
    endproperty
    a_ack_drop: assert property (p_ack_drop) else $error("request kept");
    property p_end;
        exec_q && transferEndInput |=> intrOut && !dmaReqOut;
    endproperty
    a_end: assert property (p_end) else $error("no result interrupt");
    property p_res_clear;
        !exec_q && busyOut && intrOut && hostRd && hostAddr |=> !intrOut;
    endproperty
    a_res_clear: assert property (p_res_clear) else $error("result intr kept");
endmodule : dps_phase_sequencer_chk
bind dps_phase_sequencer dps_phase_sequencer_chk i_chk (.ref_clk(ref_clk), .rst(rst),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostWr(hostWr), .hostRd(hostRd),
    .hostRdData(hostRdData), .nonDmaMode(nonDmaMode), .intrOut(intrOut),
    .dmaReqOut(dmaReqOut), .dmaAckInN(dmaAckInN), .transferEndInput(transferEndInput),
    .diskByteValid(diskByteValid), .diskByte(diskByte), .diskByteNeed(diskByteNeed),
    .busyOut(busyOut));
`default_nettype wire

// ---- test/dps_phase_sequencer_tb.sv ----
// bench: host and media stimulus, dma model, expected dma bytes from a byte queue
// assumes dps_pkg, the dma model and the checker bind compiled first
`timescale 1ns/10ps
`default_nettype none
module dps_phase_sequencer_tb;
    logic       ref_clk, rst, hostAddr, hostWr, tbRd, dmaRd, hostRd, nonDmaMode;
    logic       intrOut, dmaReqOut, dmaAckInN, transferEndInput, diskByteValid;
    logic       diskByteNeed, diskWrValid, busyOut, gotValid;
    logic [7:0] hostWrData, hostRdData, diskByte, diskWrByte, gotByte, stA, stB, stC, rdv;
    logic [3:0] lag;
    logic [7:0] expQ[$];
    int         n_mismatch = 0;
    int         compares = 0;
    bit  [31:0] seed = 32'h00000033;
    assign hostRd = tbRd | dmaRd;
    dps_phase_sequencer i_dut (.ref_clk(ref_clk), .rst(rst), .hostAddr(hostAddr),
        .hostWrData(hostWrData), .hostWr(hostWr), .hostRd(hostRd), .hostRdData(hostRdData),
        .nonDmaMode(nonDmaMode), .intrOut(intrOut), .dmaReqOut(dmaReqOut),
        .dmaAckInN(dmaAckInN), .transferEndInput(transferEndInput),
        .diskByteValid(diskByteValid), .diskByte(diskByte), .diskByteNeed(diskByteNeed),
        .diskWrByte(diskWrByte), .diskWrValid(diskWrValid), .resultStatusA(stA),
        .resultStatusB(stB), .resultStatusC(stC), .busyOut(busyOut));
    dps_dma_model i_dma (.ref_clk(ref_clk), .rst(rst), .dmaReqOut(dmaReqOut),
        .hostRdData(hostRdData), .lag(lag), .dmaAckInN(dmaAckInN), .dmaRd(dmaRd),
        .gotByte(gotByte), .gotValid(gotValid));
    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction : rnd
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    // one host access; read data sampled in the cycle after the strobe
    task automatic bus(input logic w, input logic a, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge ref_clk);
        hostAddr   <= a;
        hostWrData <= wd;
        hostWr     <= w;
        tbRd       <= ~w;
        @(posedge ref_clk);
        hostWr <= 1'h0;
        tbRd   <= 1'h0;
        #1;
        rd = hostRdData;
    endtask : bus
    task automatic media(input logic need, input logic [7:0] b);
        @(posedge ref_clk);
        diskByteValid <= ~need;
        diskByteNeed  <= need;
        diskByte      <= b;
        @(posedge ref_clk);
        diskByteValid <= 1'h0;
        diskByteNeed  <= 1'h0;
        #1;
    endtask : media
    always @(posedge ref_clk) begin
        if (gotValid && expQ.size() > 0) chk(gotByte, expQ.pop_front(), "dma byte");
    end
    task automatic run_cmd(input logic [4:0] low, input logic dma, input int n);
        logic [7:0] c[9];
        logic [7:0] r[7];
        logic [7:0] d, b, ex;
        logic       isRd;
        isRd = (low != dps_pkg::OPC_WRITE);
        ex = {1'h0, isRd, ~dma, 1'h1, 4'h0};
        @(posedge ref_clk);
        nonDmaMode <= ~dma;
        for (int i = 0; i < 9; i++) c[i] = rnd();
        c[0] = {c[0][7:5], low};
        c[1] = c[1] & dps_pkg::UNIT_BYTE_MASK;
        for (int i = 0; i < 9; i++) bus(1'h1, dps_pkg::DATA_ADDR, c[i], d);
        chk({7'h00, busyOut}, 8'h01, "busy after command");
        bus(1'h0, dps_pkg::STATUS_ADDR, 8'h00, d);
        chk(d, ex, "exec status");
        for (int k = 0; k < n; k++) begin
            b = rnd();
            d = rnd();
            lag <= {1'h0, d[2:0]};
            if (dma) expQ.push_back(b);
            media(~isRd, b);
            chk({6'h00, intrOut, dmaReqOut}, {6'h00, ~dma, dma}, "byte signal");
            if (dma) begin
                for (int t = 0; t < 40 && expQ.size() > 0; t++) @(posedge ref_clk);
                if (expQ.size() > 0) n_mismatch++;
                if (expQ.size() > 0) close_out();
            end else begin
                bus(1'h0, dps_pkg::STATUS_ADDR, 8'h00, d);
                chk(d, ex | 8'h80, "service bit");
                bus(~isRd, dps_pkg::DATA_ADDR, b, d);
                chk(isRd ? d : diskWrByte, b, "data byte");
                chk({6'h00, intrOut, diskWrValid}, {7'h00, ~isRd}, "intr clear");
            end
        end
        bus(1'h0, dps_pkg::STATUS_ADDR, 8'h00, d);
        chk(d, ex, "still in exec");
        for (int i = 0; i < 3; i++) r[i] = rnd();
        for (int i = 3; i < 7; i++) r[i] = c[i - 1];
        @(posedge ref_clk);
        {stA, stB, stC} <= {r[0], r[1], r[2]};
        transferEndInput <= 1'h1;
        @(posedge ref_clk);
        transferEndInput <= 1'h0;
        #1;
        chk({6'h00, intrOut, dmaReqOut}, 8'h02, "end intr");
        bus(1'h1, dps_pkg::DATA_ADDR, rnd(), d);
        for (int i = 0; i < 7; i++) begin
            bus(1'h0, dps_pkg::STATUS_ADDR, 8'h00, d);
            chk(d, 8'hD0, "result status");
            bus(1'h0, dps_pkg::DATA_ADDR, 8'h00, d);
            chk(d, r[i], "result byte");
            chk({7'h00, intrOut}, 8'h00, "result intr");
        end
        bus(1'h0, dps_pkg::STATUS_ADDR, 8'h00, d);
        chk(d, 8'h80, "idle status");
        chk({7'h00, busyOut}, 8'h00, "idle busy");
        $display("test done: opcode %h dma %0d", c[0], dma);
    endtask : run_cmd
    initial begin
        rst = 1'h1;
        {hostAddr, hostWr, tbRd, transferEndInput, diskByteValid, diskByteNeed} = 6'h00;
        {hostWrData, diskByte, stA, stB, stC} = 40'h0;
        nonDmaMode = 1'h1;
        lag = 4'h0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'h0;
        run_cmd(dps_pkg::OPC_READ, 1'h0, 3);
        run_cmd(dps_pkg::OPC_READ_DEL, 1'h1, 4);
        run_cmd(dps_pkg::OPC_WRITE, 1'h0, 2);
        run_cmd(dps_pkg::OPC_READ, 1'h1, 2);
        bus(1'h1, dps_pkg::DATA_ADDR, 8'h1F, rdv);
        bus(1'h0, dps_pkg::DATA_ADDR, 8'h00, rdv);
        chk(rdv, dps_pkg::STAT_INVALID, "bad opcode");
        bus(1'h0, dps_pkg::STATUS_ADDR, 8'h00, rdv);
        chk(rdv, 8'h80, "idle after bad opcode");
        $display("test done: bad opcode");
        close_out();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        close_out();
    end
endmodule : dps_phase_sequencer_tb
`default_nettype wire
